/* File: core/spc_pkg.sv */
// Purpose: Shared constants and types for the serial port control block
// Assumes: 10 MHz bus clock, byte-wide serial port
// Notes:   Register indices and field positions are named here once
package spc_pkg;
    // =========================================================
    // Register map (word index on the plain register port)
    localparam logic [1:0] SPC_ADDR_CTRL = 2'h0;  // control_reg
    localparam logic [1:0] SPC_ADDR_STAT = 2'h1;  // status_control_reg
    localparam logic [1:0] SPC_ADDR_DATA = 2'h2;  // data_reg
    localparam logic [1:0] SPC_ADDR_BRK  = 2'h3;  // break control

    // Control register fields
    localparam int SPC_C_RXIE = 7;
    localparam int SPC_C_MSTR = 5;
    localparam int SPC_C_CPOL = 4;
    localparam int SPC_C_CPHA = 3;
    localparam int SPC_C_WOM  = 2;
    localparam int SPC_C_EN   = 1;
    localparam int SPC_C_TXIE = 0;
    localparam logic [7:0] SPC_CTRL_RST = 8'h28;

    // Status/control register fields
    localparam int SPC_S_RXF  = 7;
    localparam int SPC_S_ERIE = 6;
    localparam int SPC_S_OVR  = 5;
    localparam int SPC_S_MODE_FAULT_FLAG = 4;
    localparam int SPC_S_TXE  = 3;
    localparam int SPC_S_MFEN = 2;
    localparam int SPC_S_RHI  = 1;
    localparam int SPC_S_RLO  = 0;
    localparam logic [7:0] SPC_STAT_RST = 8'h08;

    // Break register fields
    localparam int SPC_B_BREAK_FLAG_CLEAR_ENABLE = 0;
    localparam int SPC_B_BRK  = 1;

    // Master serial clock: divider of 8, 16, 32 or 64 bus cycles per bit
    localparam int SPC_CLK_HZ = 10_000_000;
    localparam int SPC_BITS   = 8;

    typedef enum logic [2:0] {
        SPC_IDLE  = 3'b001,
        SPC_SHIFT = 3'b010,
        SPC_DONE  = 3'b100
    } spc_state_t;

    typedef struct packed {
        logic out;
        logic oe;
    } spc_pin_t;
endpackage : spc_pkg

/* File: core/spc_port.sv */
// Purpose: Enable, reset, transmit queue and pin control of a serial port
// Assumes: Sync active-high reset; link clock and select sampled by i_clk
// Notes:   No interrupt logic; wake request is a level output
//
// Contract
// - System reset returns every control bit and flag to reset values.
// - Port disabled: tx empty set, transfer aborted, shifter and counter cleared, pins released.
// - Disabling keeps control bits, rate bits and receive, overrun, mode-fault flags.
// - Master mode fault with detection enabled clears the port enable bit.
// - Master starts a buffered byte right after the previous transfer ends.
// - Slave with no new byte resends the shift register contents.
// - Idle port moves buffered byte to shifter and sets tx empty within two cycles.
// - Active slave defers the buffer load until its transfer completes.
// - In wait mode the port runs, registers are locked, enabled requests wake.
// - In break with clear-enable low, data writes are dropped.
// - Wired-OR select makes MOSI open drain.
// - MISO is driven only when slave and select low.
// - Enabled port owns direction of MISO, MOSI and serial clock.
// - Master drives serial clock, slave receives it; eight cycles per byte.
// - Slave with select high ignores serial clock edges.
// - Enabled slave always takes select as input.
// - Master select use follows detection enable; disabled port releases select.
// - Master mode fault sets flag, clears enable, sets tx empty, clears counter.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spc_port
    import spc_pkg::*;
(
    input  wire logic       i_clk,       // Bus clock
    input  wire logic       i_rst,       // Sync reset, active high
    input  wire logic [1:0] i_addr,      // Register index
    input  wire logic [7:0] i_wdata,     // Write data
    input  wire logic       i_wr,        // Write strobe
    input  wire logic       i_rd,        // Read strobe
    output logic      [7:0] o_rdata,     // Read data, cycle after strobe
    input  wire logic       i_wait,      // Processor in wait mode
    input  wire logic       i_break,     // Debug break active
    output logic            o_wake,      // Enabled request pending, in wait mode only
    input  wire logic       i_sck,       // Serial clock pin in
    output logic            o_sck,       // Serial clock pin out
    output logic            o_sck_oe,    // Serial clock drive enable
    input  wire logic       i_mosi,      // MOSI pin in
    output logic            o_mosi,      // MOSI pin out
    output logic            o_mosi_oe,   // MOSI drive enable
    input  wire logic       i_miso,      // MISO pin in
    output logic            o_miso,      // MISO pin out
    output logic            o_miso_oe,   // MISO drive enable
    input  wire logic       i_ss_n,      // Slave select pin, active low
    output logic            o_ss_own     // Port owns select pin
);
    // =========================================================
    // Input synchronisers
    logic [1:0] sck_s_r, mosi_s_r, miso_s_r, ss_s_r;
    logic       sck_d_r;
    always_ff @(posedge i_clk) begin
        sck_s_r  <= {sck_s_r[0], i_sck};
        mosi_s_r <= {mosi_s_r[0], i_mosi};
        miso_s_r <= {miso_s_r[0], i_miso};
        ss_s_r   <= {ss_s_r[0], i_ss_n};
        sck_d_r  <= sck_s_r[1];
    end
    wire logic sck_q = sck_s_r[1];
    wire logic ss_q  = ss_s_r[1];

    // =========================================================
    // State
    logic [7:0] ctrl_r, ctrl_nxt, stat_r, stat_nxt, brk_r, brk_nxt;
    logic [7:0] txbuf_r, txbuf_nxt, shift_r, shift_nxt, rxbuf_r, rxbuf_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic [4:0] div_r, div_nxt;
    logic       txfull_r, txfull_nxt, sck_r, sck_nxt, half_r, half_nxt;
    logic       mosi_r, mosi_nxt, miso_r, miso_nxt;
    logic       rd_stat_r, rd_stat_nxt, ss_prev_r, ss_prev_nxt;
    spc_state_t st_r, st_nxt;

    function automatic logic [4:0] spc_div(input logic [1:0] sel);
        unique case (sel)
            // Half period of at least 4 cycles covers the MISO synchroniser
            2'h0:    spc_div = 5'h03;
            2'h1:    spc_div = 5'h07;
            2'h2:    spc_div = 5'h0F;
            default: spc_div = 5'h1F;
        endcase
    endfunction : spc_div

    logic en, mstr, cpha, cpol, mfen, fault, regs_ok;
    logic samp_edge, shft_edge, sel_on, sck_rise, sck_fall;
    always_comb begin
        en   = ctrl_r[SPC_C_EN];
        mstr = ctrl_r[SPC_C_MSTR];
        cpha = ctrl_r[SPC_C_CPHA];
        cpol = ctrl_r[SPC_C_CPOL];
        mfen = stat_r[SPC_S_MFEN];
        regs_ok = !i_wait;
        sck_rise = sck_q && !sck_d_r;
        sck_fall = !sck_q && sck_d_r;
        sel_on = !ss_q;
        // Mode fault: master sees select low, slave sees it rise mid-byte
        fault = en && mfen && (mstr ? !ss_q
                : (ss_q && !ss_prev_r && st_r == SPC_SHIFT));
        samp_edge = 1'b0;
        shft_edge = 1'b0;
        if (!mstr && sel_on) begin
            samp_edge = (cpol ^ cpha) ? sck_fall : sck_rise;
            shft_edge = (cpol ^ cpha) ? sck_rise : sck_fall;
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;  stat_nxt = stat_r;   brk_nxt = brk_r;
        txbuf_nxt = txbuf_r; shift_nxt = shift_r; rxbuf_nxt = rxbuf_r;
        bitcnt_nxt = bitcnt_r; div_nxt = div_r; txfull_nxt = txfull_r;
        sck_nxt = sck_r; half_nxt = half_r; mosi_nxt = mosi_r; miso_nxt = miso_r;
        st_nxt = st_r; rdata_nxt = 8'h00; rd_stat_nxt = rd_stat_r;
        ss_prev_nxt = ss_q;

        // =====================================================
        // Register reads
        if (i_rd && regs_ok) begin
            unique case (i_addr)
                SPC_ADDR_CTRL: rdata_nxt = ctrl_r;
                SPC_ADDR_STAT: rdata_nxt = stat_r;
                SPC_ADDR_DATA: rdata_nxt = rxbuf_r;
                default:       rdata_nxt = brk_r;
            endcase
            if (i_addr == SPC_ADDR_STAT)
                rd_stat_nxt = 1'b1;
            if (i_addr == SPC_ADDR_DATA && rd_stat_r) begin
                stat_nxt[SPC_S_RXF] = 1'b0;
                stat_nxt[SPC_S_OVR] = 1'b0;
                rd_stat_nxt = 1'b0;
            end
        end
        // Register writes; control bits survive disable
        if (i_wr && regs_ok) begin
            unique case (i_addr)
                SPC_ADDR_CTRL: begin
                    ctrl_nxt = {i_wdata[7], 1'b0, i_wdata[5:0]};
                    if (rd_stat_r && !fault)
                        stat_nxt[SPC_S_MODE_FAULT_FLAG] = 1'b0;
                end
                SPC_ADDR_STAT: begin
                    stat_nxt[SPC_S_ERIE] = i_wdata[SPC_S_ERIE];
                    stat_nxt[SPC_S_MFEN] = i_wdata[SPC_S_MFEN];
                    stat_nxt[SPC_S_RHI]  = i_wdata[SPC_S_RHI];
                    stat_nxt[SPC_S_RLO]  = i_wdata[SPC_S_RLO];
                end
                SPC_ADDR_DATA: begin
                    // Writes while full are the writer's fault and overwrite
                    if (!(i_break && !brk_r[SPC_B_BREAK_FLAG_CLEAR_ENABLE])) begin
                        txbuf_nxt = i_wdata;
                        txfull_nxt = 1'b1;
                        stat_nxt[SPC_S_TXE] = 1'b0;
                    end
                end
                default: brk_nxt[SPC_B_BREAK_FLAG_CLEAR_ENABLE] = i_wdata[SPC_B_BREAK_FLAG_CLEAR_ENABLE];
            endcase
        end
        brk_nxt[SPC_B_BRK] = i_break;

        // =====================================================
        // Transfer engine
        if (!ctrl_nxt[SPC_C_EN] || !en) begin
            st_nxt = SPC_IDLE;
            shift_nxt = 8'h00;
            bitcnt_nxt = 4'h0;
            div_nxt = 5'h00;
            half_nxt = 1'b0;
            txfull_nxt = 1'b0;
            stat_nxt[SPC_S_TXE] = 1'b1;
            sck_nxt = cpol;
        end else begin
            unique case (st_r)
                SPC_IDLE: begin
                    sck_nxt = cpol;
                    if (txfull_r) begin
                        shift_nxt = txbuf_r;
                        txfull_nxt = 1'b0;
                        stat_nxt[SPC_S_TXE] = 1'b1;
                        if (mstr)
                            st_nxt = SPC_SHIFT;
                    end
                    if (!mstr && sel_on && (!cpha ? ss_prev_r : samp_edge | shft_edge))
                        st_nxt = SPC_SHIFT;
                    miso_nxt = shift_nxt[7];
                    mosi_nxt = shift_nxt[7];
                end
                SPC_SHIFT: begin
                    if (mstr) begin
                        if (div_r == 5'h00) begin
                            div_nxt = spc_div(stat_r[SPC_S_RHI:SPC_S_RLO]);
                            half_nxt = !half_r;
                            sck_nxt = !sck_r;
                            // Sample on leading edge in phase 0, trailing in phase 1
                            if (!(half_r ^ cpha)) begin
                                shift_nxt = {shift_r[6:0], miso_s_r[1]};
                                bitcnt_nxt = bitcnt_r + 4'h1;
                            end else begin
                                mosi_nxt = shift_r[7];
                            end
                            if (half_r && bitcnt_r == 4'(SPC_BITS - 1) + 4'(!cpha))
                                st_nxt = SPC_DONE;
                        end else begin
                            div_nxt = div_r - 5'h01;
                        end
                    end else begin
                        if (samp_edge) begin
                            shift_nxt = {shift_r[6:0], mosi_s_r[1]};
                            bitcnt_nxt = bitcnt_r + 4'h1;
                            if (bitcnt_r == 4'(SPC_BITS - 1))
                                st_nxt = SPC_DONE;
                        end
                        if (shft_edge && !(cpha && bitcnt_r == 4'h0))
                            miso_nxt = shift_r[7];
                    end
                end
                default: begin
                    // Slave keeps the received byte in shifter to resend
                    if (stat_r[SPC_S_RXF])
                        stat_nxt[SPC_S_OVR] = 1'b1;
                    else begin
                        rxbuf_nxt = shift_r;
                        stat_nxt[SPC_S_RXF] = 1'b1;
                    end
                    bitcnt_nxt = 4'h0;
                    half_nxt = 1'b0;
                    sck_nxt = cpol;
                    st_nxt = SPC_IDLE;
                end
            endcase
        end
        if (fault) begin
            stat_nxt[SPC_S_MODE_FAULT_FLAG] = 1'b1;
            if (mstr) begin
                ctrl_nxt[SPC_C_EN] = 1'b0;
                stat_nxt[SPC_S_TXE] = 1'b1;
                bitcnt_nxt = 4'h0;
                st_nxt = SPC_IDLE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r <= SPC_CTRL_RST;   stat_r <= SPC_STAT_RST;  brk_r <= 8'h00;
            txbuf_r <= 8'h00;  shift_r <= 8'h00;  rxbuf_r <= 8'h00;
            rdata_r <= 8'h00;  bitcnt_r <= 4'h0;  div_r <= 5'h00;
            txfull_r <= 1'b0;  sck_r <= 1'b0;  half_r <= 1'b0;
            mosi_r <= 1'b1;  miso_r <= 1'b0;  rd_stat_r <= 1'b0;
            ss_prev_r <= 1'b1;  st_r <= SPC_IDLE;
        end else begin
            ctrl_r <= ctrl_nxt;  stat_r <= stat_nxt;  brk_r <= brk_nxt;
            txbuf_r <= txbuf_nxt;  shift_r <= shift_nxt;  rxbuf_r <= rxbuf_nxt;
            rdata_r <= rdata_nxt;  bitcnt_r <= bitcnt_nxt;  div_r <= div_nxt;
            txfull_r <= txfull_nxt;  sck_r <= sck_nxt;  half_r <= half_nxt;
            mosi_r <= mosi_nxt;  miso_r <= miso_nxt;  rd_stat_r <= rd_stat_nxt;
            ss_prev_r <= ss_prev_nxt;  st_r <= st_nxt;
        end
    end

    // =========================================================
    // Pin control, all registered
    spc_pin_t sck_p, mosi_p, miso_p;
    logic     own_ss, wake;
    always_comb begin
        sck_p  = '{out: sck_r, oe: en && mstr};
        // Open drain drives only the low level
        mosi_p = '{out: mosi_r, oe: en && mstr && !(ctrl_r[SPC_C_WOM] && mosi_r)};
        miso_p = '{out: miso_r, oe: en && !mstr && sel_on};
        own_ss = en && (!mstr || mfen);
        wake   = en && ((ctrl_r[SPC_C_RXIE] && stat_r[SPC_S_RXF])
               || (ctrl_r[SPC_C_TXIE] && stat_r[SPC_S_TXE]))
               || (stat_r[SPC_S_ERIE] && (stat_r[SPC_S_OVR] || stat_r[SPC_S_MODE_FAULT_FLAG]));
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sck <= 1'b0;  o_sck_oe <= 1'b0;  o_mosi <= 1'b1;  o_mosi_oe <= 1'b0;
            o_miso <= 1'b0;  o_miso_oe <= 1'b0;  o_ss_own <= 1'b0;  o_wake <= 1'b0;
        end else begin
            o_sck <= sck_p.out;  o_sck_oe <= sck_p.oe;
            o_mosi <= mosi_p.out;  o_mosi_oe <= mosi_p.oe;
            o_miso <= miso_p.out;  o_miso_oe <= miso_p.oe;
            o_ss_own <= own_ss;
            o_wake <= i_wait && wake;
        end
    end
    assign o_rdata = rdata_r;
endmodule : spc_port
`default_nettype wire

/* File: bench/spc_port_assertions.sv */
// Purpose: Port-level checks of the serial port control block
// Assumes: Only the top module ports are visible
// Notes:   Bound into every spc_port instance
`timescale 1ns/1ps
`default_nettype none
module spc_port_assertions (
    input wire logic       i_clk, i_rst, i_rd, i_wait, i_ss_n, // Clock, reset, bus and pins
    input wire logic [7:0] o_rdata,                            // Read data
    input wire logic       o_wake, o_sck_oe, o_mosi_oe,        // Wake and drive enables
    input wire logic       o_miso_oe, o_ss_own                 // Slave drive, select owner
);
    // ==========================================================
    // Properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    reset_values_a: assert property ($past(i_rst) |-> o_rdata == 8'h00 && !o_sck_oe
        && !o_mosi_oe && !o_miso_oe) else $error("outputs not at reset values");
    read_quiet_a: assert property ($past(i_wait) || !$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside a taken read");
    port_roles_a: assert property (o_miso_oe |-> !o_sck_oe && !o_mosi_oe)
        else $error("slave and master drives together");
    ss_owner_a: assert property (o_miso_oe |-> o_ss_own)
        else $error("slave drives without owning select");
    mosi_master_a: assert property (o_mosi_oe |-> o_sck_oe)
        else $error("data driven without clock drive");
    miso_release_a: assert property (i_ss_n [*6] |-> !o_miso_oe)
        else $error("slave output driven while deselected");
    mode_fault_a: assert property (o_sck_oe && o_ss_own && !i_ss_n |-> ##[1:5] !o_sck_oe)
        else $error("master kept driving after select fault");
    wake_wait_a: assert property (o_wake |-> $past(i_wait))
        else $error("wake raised outside wait");
endmodule : spc_port_assertions
bind spc_port spc_port_assertions spc_port_assertions_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_rd(i_rd), .i_wait(i_wait), .i_ss_n(i_ss_n), .o_rdata(o_rdata), .o_wake(o_wake),
    .o_sck_oe(o_sck_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .o_ss_own(o_ss_own));
`default_nettype wire

/* File: bench/spc_slave_model.sv */
// Purpose: Far-side slave device for master-mode traffic
// Assumes: Clock phase 1, idle-low clock
// Notes:   Released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
    input  wire logic       i_sck,   // Serial clock
    input  wire logic       i_mosi,  // Data from master
    input  wire logic       i_sel_n, // Select, active low
    input  wire logic       i_slow,  // Late answer
    input  wire logic [7:0] i_tx,    // Answer byte
    output logic            o_miso,  // Data to master
    output logic [7:0]      o_rx,    // Last byte received
    output logic            o_got    // Pulse per byte
);
    logic [7:0] sh = 8'h00;
    int         n  = 0;
    initial begin
        o_miso = 1'b0;
        o_rx = 8'h00;
        o_got = 1'b0;
    end
    // Drive on the leading edge, sample on the trailing edge, MSB first
    always @(posedge i_sck) if (!i_sel_n) begin
        if (n == 0) sh = i_tx;
        o_miso <= #(i_slow ? 600 : 5) sh[7];
    end
    always @(negedge i_sck) if (!i_sel_n) begin
        sh = {sh[6:0], i_mosi};
        n = n + 1;
        if (n == 8) begin
            n = 0;
            o_rx <= sh;
            o_got <= #1 1'b1;
            o_got <= #50 1'b0;
        end
    end
    always @(posedge i_sel_n) begin
        n = 0;
        o_miso <= ~o_miso;
    end
endmodule : spc_slave_model
`default_nettype wire

/* File: bench/spc_port_test.sv */
// Purpose: Self-checking bench of the serial port control block
// Assumes: 10 MHz clock, 800 ns link clock in slave frames
// Notes:   Expected results queue up and a watcher compares them
`timescale 1ns/1ps
`default_nettype none
module spc_port_test;
    import spc_pkg::*;
    logic clk, rst, wr, rd, wt, brk, b_sck, b_mosi, ss_n, sel_n, slow, rd_d;
    logic sck, sck_oe, mosi, mosi_oe, miso, miso_oe, m_miso, m_got, wake, own;
    logic [1:0]  addr;
    logic [7:0]  wd, tx, m_rx, link_b, rdata;
    logic [15:0] rq;
    logic [31:0] lfsr = 32'hC5A2;
    logic [15:0] rd_q[$];
    logic [7:0]  link_q[$];
    int          miscompares = 0;
    int          total_checks = 0;
    event        link_ev;
    wire logic sck_w = sck_oe ? sck : b_sck;
    wire logic mosi_w = mosi_oe ? mosi : b_mosi;
    wire logic miso_w = miso_oe ? miso : m_miso;
    spc_port spc_port_inst (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_wait(wt), .i_break(brk), .o_wake(wake), .i_sck(sck_w),
        .o_sck(sck), .o_sck_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
        .i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe), .i_ss_n(ss_n), .o_ss_own(own));
    spc_slave_model spc_slave_model_inst (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(sel_n),
        .i_slow(slow), .i_tx(tx), .o_miso(m_miso), .o_rx(m_rx), .o_got(m_got));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic end_sim;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        rd_q.push_back({m, e & m});
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
    endtask : rreg
    task automatic waitq(input int n);
        repeat (n) @(posedge clk);
        cmp("link pending", 8'h00, 8'(link_q.size()));
    endtask : waitq
    always @(posedge clk) begin
        if (rd_d) begin
            rq = rd_q.pop_front();
            cmp("rdata", rq[7:0], rdata & rq[15:8]);
        end
        rd_d <= rd;
    end
    always @(posedge m_got) begin
        link_b = m_rx;
        ->link_ev;
    end
    always @(link_ev) cmp("link", link_q.size() ? link_q.pop_front() : 8'hXX, link_b);
    task automatic master_run(input logic [1:0] rate);
        int hp;
        lfsr = nxt(lfsr);
        hp = 4 << rate;
        slow = (rate == 2'h3);
        tx = ~lfsr[7:0];
        wreg(SPC_ADDR_STAT, {6'h00, rate});
        wreg(SPC_ADDR_CTRL, 8'h2A | {5'h00, rate[0], 2'h0});
        link_q.push_back(lfsr[7:0]);
        link_q.push_back(lfsr[15:8]);
        wreg(SPC_ADDR_DATA, lfsr[7:0]);
        rreg(SPC_ADDR_STAT, 8'h08, 8'h08);
        wreg(SPC_ADDR_DATA, lfsr[15:8]);
        rreg(SPC_ADDR_STAT, 8'h00, 8'h08);
        waitq(36 * hp + 40);
        rreg(SPC_ADDR_STAT, 8'hA8, 8'hA8);
        rreg(SPC_ADDR_DATA, ~lfsr[7:0], 8'hFF);
        $display("master rate %0d done", rate);
    endtask : master_run
    task automatic sxfer(input logic [7:0] mo, input logic [7:0] ex, input logic mid);
        logic [7:0] cap;
        link_q.push_back(ex);
        @(posedge clk); ss_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            b_sck <= 1'b1;
            b_mosi <= mo[i];
            repeat (4) @(posedge clk); b_sck <= 1'b0;
            repeat (2) @(posedge clk); cap[i] = miso_w;
            if (mid && i == 4) wreg(SPC_ADDR_DATA, ~ex);
            else if (mid && i == 3) rreg(SPC_ADDR_STAT, 8'h00, 8'h08);
            else repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk); ss_n <= 1'b1;
        link_b = cap;
        ->link_ev;
        repeat (8) @(posedge clk);
        cmp("miso oe", 8'h00, {7'h00, miso_oe});
    endtask : sxfer
    // ==========================================================
    // Main sequence
    initial begin
        {rst, wr, rd, wt, brk, b_sck, b_mosi, ss_n, sel_n, slow, rd_d} = 11'h418;
        addr = 2'h0; wd = 8'h00; tx = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rreg(SPC_ADDR_CTRL, SPC_CTRL_RST, 8'hFF);
        rreg(SPC_ADDR_STAT, SPC_STAT_RST, 8'hFF);
        for (int r = 0; r < 4; r++) master_run(2'(r));
        wreg(SPC_ADDR_STAT, 8'h47);
        link_q.push_back(8'hA5);
        wreg(SPC_ADDR_DATA, 8'hA5);
        waitq(640);
        wreg(SPC_ADDR_DATA, 8'h3C);
        repeat (60) @(posedge clk);
        wreg(SPC_ADDR_CTRL, 8'hAC);
        sel_n <= 1'b1;
        rreg(SPC_ADDR_STAT, 8'hCF, 8'hFF);
        rreg(SPC_ADDR_CTRL, 8'hAC, 8'hFF);
        cmp("pins", 8'h00, {6'h00, sck_oe, mosi_oe});
        sel_n <= 1'b0;
        wreg(SPC_ADDR_CTRL, 8'h2E);
        link_q.push_back(8'h5A);
        wreg(SPC_ADDR_DATA, 8'h5A);
        waitq(640);
        ss_n <= 1'b0;
        repeat (8) @(posedge clk);
        rreg(SPC_ADDR_STAT, 8'h18, 8'h18);
        rreg(SPC_ADDR_CTRL, 8'h00, 8'h02);
        ss_n <= 1'b1;
        wreg(SPC_ADDR_CTRL, 8'h2B);
        wreg(SPC_ADDR_BRK, 8'h00);
        brk <= 1'b1;
        wreg(SPC_ADDR_DATA, 8'hFF);
        repeat (40) @(posedge clk);
        rreg(SPC_ADDR_STAT, 8'h08, 8'h08);
        brk <= 1'b0;
        wt <= 1'b1;
        repeat (4) @(posedge clk);
        cmp("wake", 8'h01, {7'h00, wake});
        rreg(SPC_ADDR_STAT, 8'h00, 8'hFF);
        wt <= 1'b0;
        $display("master control done");
        sel_n <= 1'b1;
        lfsr = nxt(lfsr);
        wreg(SPC_ADDR_CTRL, 8'h0A);
        wreg(SPC_ADDR_DATA, lfsr[7:0]);
        rreg(SPC_ADDR_STAT, 8'h08, 8'h08);
        sxfer(lfsr[7:0], lfsr[7:0], 1'b0);
        sxfer(lfsr[7:0], lfsr[7:0], 1'b1);
        repeat (3) begin
            b_sck <= 1'b1;
            repeat (4) @(posedge clk); b_sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        sxfer(~lfsr[7:0], ~lfsr[7:0], 1'b0);
        $display("slave done");
        end_sim();
    end
    initial begin
        #2_000_000;
        miscompares++;
        end_sim();
    end
endmodule : spc_port_test
`default_nettype wire
